// >>> sfr_dev.sv
/*
 Device end of the serial flash read path: decodes read commands,
 captures the address, counts dummy clocks and streams array bytes.
 Assumes the link pins arrive asynchronously and that sck runs well
 below a quarter of clk, since both edges are found by sampling.
*/
// Operation
// - Normal read is 03h plus three address bytes
// - Decode only address bits valid for density
// - Ignore input lines after normal read address
// - Normal read data leaves msb first
// - Read address increments after every byte
// - Address wraps to zero past array top
// - Raising chip enable ends the read
// - Reads refused while write in progress
// - Fast read uses opcode 0Bh
// - Command and address sampled on rising edge
// - Data updated on falling edge
// - Single line fast read: eight dummy cycles
// - Four line fast read: six dummy cycles
// - Dual output read: eight dummy cycles
// - Dual io read: four dummy cycles
// - Quad output read: eight dummy cycles
// - Quad io read: six dummy cycles
// - Id and info reads use fast dummies
// - Mode byte clocks count within dummy period
// - Unique id ignores A23..A9, A8..A4 zero
// - Four line mode: opcode 2, address 6 clocks
`include "sfr_cfg.svh"
module sfr_dev
  import sfr_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  sfr_if.dev link, // Serial link
  input wire logic write_in_progress_flag, // Internal write busy
  input wire logic four_line_command_mode, // Commands on four lines
  input wire logic [2:0] density_sel, // 0 4Mb .. 4 256Kb
  input wire logic load_we, // Array load strobe
  input wire logic load_aux, // Load id/info area
  input wire logic [18:0] load_addr, // Load address
  input wire logic [7:0] load_data, // Load byte
  output logic busy, // Frame selected
  output logic refused // Read dropped while busy
);

  typedef struct packed {
    logic s1_sck;
    logic s2_sck;
    logic prev_sck;
    logic s1_cs;
    logic s2_cs;
    logic [3:0] s1_io;
    logic [3:0] s2_io;
    sfr_dstate_e st;
    logic four_line;
    logic [7:0] op;
    logic [23:0] addr;
    logic [5:0] cnt;
    logic [5:0] dummy;
    sfr_width_t aw;
    sfr_width_t dw;
    logic aux;
    logic [7:0] sh;
    logic [3:0] left;
    logic [3:0] out;
    logic [3:0] oe;
    logic busy;
    logic refused;
  } sfr_dev_s;

  sfr_dev_s q;
  sfr_dev_s next_q;
  logic [7:0] mem [0:(1 << `SFR_ARRAY_BITS) - 1];
  logic [7:0] aux_mem [0:(1 << `SFR_AUX_BITS) - 1];

  ////////////////////////////////////////////////////////////////////////
  // Address helpers

  function automatic logic [23:0] sfr_mask(input logic [2:0] sel, input logic aux);
    int top;
    case (sel)
      3'h1: top = `SFR_TOP_2M;
      3'h2: top = `SFR_TOP_1M;
      3'h3: top = `SFR_TOP_512K;
      3'h4: top = `SFR_TOP_256K;
      default: top = `SFR_TOP_4M;
    endcase
    if (aux) top = `SFR_AUX_BITS - 1;
    return 24'((25'h1 << (top + 1)) - 25'h1);
  endfunction

  logic [23:0] mask;
  logic [7:0] rd_byte;
  logic rise;
  logic fall;
  logic [3:0] nib;
  logic [5:0] cw;

  always_comb begin
    mask = sfr_mask(density_sel, q.aux);
    rd_byte = q.aux ? aux_mem[q.addr[`SFR_AUX_BITS-1:0] & mask[`SFR_AUX_BITS-1:0]]
                    : mem[q.addr[`SFR_ARRAY_BITS-1:0] & mask[`SFR_ARRAY_BITS-1:0]];
    rise = q.s2_sck & ~q.prev_sck;
    fall = ~q.s2_sck & q.prev_sck;
    nib = q.s2_io;
    cw = q.four_line ? 6'h04 : 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Array load port; the array holds the whole 4Mb, smaller parts mask it

  always_ff @(posedge clk) begin
    if (load_we) begin
      if (load_aux) begin
        aux_mem[load_addr[`SFR_AUX_BITS-1:0]] <= load_data;
      end else begin
        mem[load_addr] <= load_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link state

  always_comb begin
    logic [7:0] b;
    logic [7:0] op;
    logic [3:0] lft;
    b = 8'h00;
    op = 8'h00;
    lft = 4'h0;
    next_q = q;
    next_q.s1_sck = link.sck;
    next_q.s2_sck = q.s1_sck;
    next_q.prev_sck = q.s2_sck;
    next_q.s1_cs = link.cs_n;
    next_q.s2_cs = q.s1_cs;
    next_q.s1_io = link.io;
    next_q.s2_io = q.s1_io;
    next_q.refused = 1'b0;
    if (q.s2_cs) begin
      // Deselect ends any phase at once, mid byte included
      next_q.st = SFR_D_IDLE;
      next_q.oe = 4'h0;
      next_q.busy = 1'b0;
    end else begin
      next_q.busy = 1'b1;
      case (q.st)
        SFR_D_IDLE: begin
          next_q.st = SFR_D_CMD;
          next_q.four_line = four_line_command_mode;
          next_q.op = 8'h00;
          next_q.cnt = 6'h00;
          next_q.oe = 4'h0;
        end
        SFR_D_CMD: begin
          if (rise) begin
            op = sfr_take(q.op, nib, 3'(cw));
            next_q.op = op;
            next_q.cnt = q.cnt + cw;
            if (q.cnt + cw == 6'h08) begin
              next_q.cnt = 6'h00;
              if (!sfr_is_read(op, q.four_line)) begin
                next_q.st = SFR_D_IGNORE;
              end else if (write_in_progress_flag) begin
                next_q.st = SFR_D_IGNORE;
                next_q.refused = 1'b1;
              end else begin
                next_q.st = SFR_D_ADDR;
                next_q.aw = sfr_addr_w(op, q.four_line);
                next_q.dw = sfr_data_w(op, q.four_line);
                next_q.dummy = sfr_dummy(op, q.four_line);
                next_q.aux = (op == `SFR_OP_UID) || (op == `SFR_OP_INFO);
                next_q.addr = 24'h000000;
              end
            end
          end
        end
        SFR_D_ADDR: begin
          if (rise) begin
            // All 24 bits are taken; masking happens at the array
            next_q.addr = (q.addr << q.aw) | 24'(nib & sfr_lanes(q.aw));
            next_q.cnt = q.cnt + 6'(q.aw);
            if (q.cnt + 6'(q.aw) == 6'd24) begin
              next_q.cnt = 6'h00;
              next_q.left = 4'h0;
              next_q.st = (q.dummy == 6'h00) ? SFR_D_DATA : SFR_D_DUMMY;
            end
          end
        end
        SFR_D_DUMMY: begin
          // Any mode byte sent by the host is absorbed here
          if (rise) begin
            next_q.cnt = q.cnt + 6'h01;
            if (q.cnt + 6'h01 == q.dummy) begin
              next_q.st = SFR_D_DATA;
            end
          end
        end
        SFR_D_DATA: begin
          // Input lines are not looked at in this phase
          if (fall) begin
            b = (q.left == 4'h0) ? rd_byte : q.sh;
            lft = (q.left == 4'h0) ? 4'h8 : q.left;
            next_q.left = lft - 4'(q.dw);
            next_q.sh = b << q.dw;
            next_q.oe = (q.dw == 3'h1) ? 4'h2 : sfr_lanes(q.dw);
            case (q.dw)
              3'h1: next_q.out = {2'b00, b[7], 1'b0};
              3'h2: next_q.out = {2'b00, b[7:6]};
              default: next_q.out = b[7:4];
            endcase
            if (q.left == 4'h0) begin
              next_q.addr = (q.addr + 24'h000001) & mask;
            end
          end
        end
        SFR_D_IGNORE: begin
          next_q.oe = 4'h0;
        end
        default: begin
          next_q.st = SFR_D_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.s1_sck <= 1'b0;
      q.s1_cs <= 1'b1;
      q.s2_cs <= 1'b1;
      q.st <= SFR_D_IDLE;
      q.aw <= 3'h1;
      q.dw <= 3'h1;
    end else begin
      q <= next_q;
    end
  end

  assign link.d_out = q.out;
  assign link.d_oe = q.oe;
  assign busy = q.busy;
  assign refused = q.refused;

endmodule // sfr_dev

// >>> sfr_cfg.svh
/*
 Constants of the serial flash read path: opcodes, dummy counts,
 density address tops and link timing.
 Assumes a 100 MHz system clock on both ends.
*/
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_OP_NORMAL 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL_OUT 8'h3B
`define SFR_OP_DUAL_IO 8'hBB
`define SFR_OP_QUAD_OUT 8'h6B
`define SFR_OP_QUAD_IO 8'hEB
`define SFR_OP_UID 8'h4B
`define SFR_OP_INFO 8'h68

`define SFR_DUMMY_FAST_SPI 6'h08
`define SFR_DUMMY_FAST_FOUR 6'h06
`define SFR_DUMMY_DUAL_OUT 6'h08
`define SFR_DUMMY_DUAL_IO 6'h04
`define SFR_DUMMY_QUAD_OUT 6'h08
`define SFR_DUMMY_QUAD_IO 6'h06

`define SFR_ADDR_BITS 24
`define SFR_ARRAY_BITS 19
`define SFR_AUX_BITS 9
`define SFR_TOP_4M 18
`define SFR_TOP_2M 17
`define SFR_TOP_1M 16
`define SFR_TOP_512K 15
`define SFR_TOP_256K 14

`define SFR_NORMAL_MAX_MHZ 50
`define SFR_FAST_MAX_MHZ 104
`define SFR_CLK_MHZ 100
`define SFR_HOST_SCK_NS 160
`define SFR_HOST_HALF ((`SFR_HOST_SCK_NS * `SFR_CLK_MHZ) / 2000)

`endif

// >>> sfr_pkg.sv
/*
 Types and lane decoding shared by both ends of the read link.
 Assumes sfr_cfg.svh is on the include path.
*/
`include "sfr_cfg.svh"
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_D_IDLE = 3'h0, SFR_D_CMD = 3'h1, SFR_D_ADDR = 3'h2,
    SFR_D_DUMMY = 3'h3, SFR_D_DATA = 3'h4, SFR_D_IGNORE = 3'h5
  } sfr_dstate_e;
  typedef enum logic [2:0] {
    SFR_H_IDLE = 3'h0, SFR_H_CMD = 3'h1, SFR_H_ADDR = 3'h2,
    SFR_H_DUMMY = 3'h3, SFR_H_DATA = 3'h4
  } sfr_hstate_e;
  typedef logic [2:0] sfr_width_t;

  function automatic sfr_width_t sfr_addr_w(input logic [7:0] op, input logic four_line);
    if (four_line || op == `SFR_OP_QUAD_IO) return 3'h4;
    if (op == `SFR_OP_DUAL_IO) return 3'h2;
    return 3'h1;
  endfunction

  function automatic sfr_width_t sfr_data_w(input logic [7:0] op, input logic four_line);
    if (four_line || op == `SFR_OP_QUAD_OUT || op == `SFR_OP_QUAD_IO) return 3'h4;
    if (op == `SFR_OP_DUAL_OUT || op == `SFR_OP_DUAL_IO) return 3'h2;
    return 3'h1;
  endfunction

  function automatic logic [5:0] sfr_dummy(input logic [7:0] op, input logic four_line);
    case (op)
      `SFR_OP_FAST, `SFR_OP_UID, `SFR_OP_INFO: return four_line ? `SFR_DUMMY_FAST_FOUR : `SFR_DUMMY_FAST_SPI;
      `SFR_OP_DUAL_OUT: return `SFR_DUMMY_DUAL_OUT;
      `SFR_OP_DUAL_IO: return `SFR_DUMMY_DUAL_IO;
      `SFR_OP_QUAD_OUT: return `SFR_DUMMY_QUAD_OUT;
      `SFR_OP_QUAD_IO: return `SFR_DUMMY_QUAD_IO;
      default: return 6'h00;
    endcase
  endfunction

  function automatic logic sfr_is_read(input logic [7:0] op, input logic four_line);
    case (op)
      `SFR_OP_FAST, `SFR_OP_QUAD_IO, `SFR_OP_UID, `SFR_OP_INFO: return 1'b1;
      `SFR_OP_NORMAL, `SFR_OP_DUAL_OUT, `SFR_OP_DUAL_IO, `SFR_OP_QUAD_OUT: return !four_line;
      default: return 1'b0;
    endcase
  endfunction

  // Shift w bits of nib (lsb aligned) into sh, msb first
  function automatic logic [7:0] sfr_take(input logic [7:0] sh, input logic [3:0] nib, input sfr_width_t w);
    case (w)
      3'h1: return {sh[6:0], nib[0]};
      3'h2: return {sh[5:0], nib[1:0]};
      default: return {sh[3:0], nib};
    endcase
  endfunction

  function automatic logic [3:0] sfr_lanes(input sfr_width_t w);
    case (w)
      3'h1: return 4'h1;
      3'h2: return 4'h3;
      default: return 4'hF;
    endcase
  endfunction
endpackage

// >>> sfr_if.sv
/*
 Serial link between flash controller and flash read path.
 Four data lines resolve from the two enables; an undriven line reads high.
*/
interface sfr_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] io;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = h_oe[i] ? h_out[i] : (d_oe[i] ? d_out[i] : 1'b1);
    end
  end
  modport host (output sck, output cs_n, output h_out, output h_oe, input io);
  modport dev (input sck, input cs_n, input io, output d_out, output d_oe);
endinterface

// >>> sfr_host.sv
/*
 Controller end of the serial flash read link: issues one read frame
 per start request and returns the bytes read.
 Assumes the user only requests opcodes legal in the chosen mode.
*/
`include "sfr_cfg.svh"
module sfr_host
  import sfr_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  sfr_if.host link, // Serial link
  input wire logic start, // Begin a read frame
  input wire logic [7:0] opcode, // Read opcode
  input wire logic [23:0] address, // Start address
  input wire logic [15:0] byte_count, // Bytes to read, 0 means 1
  input wire logic four_line_command_mode, // Commands on four lines
  output logic ready, // Start accepted now
  output logic [7:0] rd_data, // Byte read
  output logic rd_valid, // rd_data valid pulse
  output logic done // Frame closed pulse
);

  typedef struct packed {
    logic [3:0] s1_io;
    logic [3:0] s2_io;
    sfr_hstate_e st;
    logic [4:0] div;
    logic sck;
    logic cs_n;
    logic [31:0] tx;
    logic [19:0] cnt;
    sfr_width_t w;
    sfr_width_t aw;
    sfr_width_t dw;
    logic [5:0] dummy;
    logic [19:0] dclk;
    logic [7:0] rx;
    logic [3:0] bits;
    logic [3:0] out;
    logic [3:0] oe;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
  } sfr_host_s;

  sfr_host_s q;
  sfr_host_s next_q;
  localparam logic [4:0] HALF = 5'(`SFR_HOST_HALF);

  always_comb begin
    logic [3:0] nib;
    logic [19:0] nb;
    nib = 4'h0;
    nb = 20'h00000;
    next_q = q;
    next_q.s1_io = link.io;
    next_q.s2_io = q.s1_io;
    next_q.rd_valid = 1'b0;
    next_q.done = 1'b0;
    if (q.div != HALF - 5'h01) begin
      next_q.div = q.div + 5'h01;
    end
    case (q.st)
      SFR_H_IDLE: begin
        // cs_n stays high a full half period between frames
        if (start && q.div == HALF - 5'h01) begin
          nb = (byte_count == 16'h0000) ? 20'h00001 : {4'h0, byte_count};
          next_q.st = SFR_H_CMD;
          next_q.cs_n = 1'b0;
          next_q.div = 5'h00;
          next_q.tx = {opcode, address};
          next_q.w = four_line_command_mode ? 3'h4 : 3'h1;
          next_q.cnt = four_line_command_mode ? 20'h00002 : 20'h00008;
          next_q.aw = sfr_addr_w(opcode, four_line_command_mode);
          next_q.dw = sfr_data_w(opcode, four_line_command_mode);
          next_q.dummy = sfr_dummy(opcode, four_line_command_mode);
          next_q.dclk = (nb << 3) >> ((sfr_data_w(opcode, four_line_command_mode) == 3'h4) ? 2 :
                        (sfr_data_w(opcode, four_line_command_mode) == 3'h2) ? 1 : 0);
          next_q.bits = 4'h0;
          next_q.out = opcode[7:4] >> (four_line_command_mode ? 0 : 3);
          next_q.oe = four_line_command_mode ? 4'hF : 4'h1;
        end
      end
      default: begin
        if (q.div == HALF - 5'h01) begin
          next_q.div = 5'h00;
          if (!q.sck) begin
            next_q.sck = 1'b1;
            if (q.st == SFR_H_DATA) begin
              nib = (q.dw == 3'h1) ? {3'b000, q.s2_io[1]} : q.s2_io;
              next_q.rx = sfr_take(q.rx, nib, q.dw);
              next_q.bits = q.bits + 4'(q.dw);
              if (q.bits + 4'(q.dw) == 4'h8) begin
                next_q.bits = 4'h0;
                next_q.rd_data = sfr_take(q.rx, nib, q.dw);
                next_q.rd_valid = 1'b1;
              end
            end
          end else begin
            next_q.sck = 1'b0;
            next_q.tx = q.tx << q.w;
            next_q.cnt = q.cnt - 20'h00001;
            if (q.cnt == 20'h00001) begin
              case (q.st)
                SFR_H_CMD: begin
                  next_q.st = SFR_H_ADDR;
                  next_q.w = q.aw;
                  next_q.cnt = 20'(24 / q.aw);
                end
                SFR_H_ADDR: begin
                  next_q.st = (q.dummy == 6'h00) ? SFR_H_DATA : SFR_H_DUMMY;
                  next_q.cnt = (q.dummy == 6'h00) ? q.dclk : {14'h0, q.dummy};
                end
                SFR_H_DUMMY: begin
                  next_q.st = SFR_H_DATA;
                  next_q.cnt = q.dclk;
                end
                default: begin
                  // Frame closed only after the last data clock
                  next_q.st = SFR_H_IDLE;
                  next_q.cs_n = 1'b1;
                  next_q.done = 1'b1;
                end
              endcase
            end
            if (next_q.st == SFR_H_CMD || next_q.st == SFR_H_ADDR) begin
              next_q.oe = sfr_lanes(next_q.w);
              next_q.out = next_q.tx[31:28] >> (3'h4 - next_q.w);
            end else begin
              next_q.oe = 4'h0;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= SFR_H_IDLE;
      q.cs_n <= 1'b1;
      q.w <= 3'h1;
      q.aw <= 3'h1;
      q.dw <= 3'h1;
    end else begin
      q <= next_q;
    end
  end

  assign link.sck = q.sck;
  assign link.cs_n = q.cs_n;
  assign link.h_out = q.out;
  assign link.h_oe = q.oe;
  assign ready = (q.st == SFR_H_IDLE) && (q.div == HALF - 5'h01);
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign done = q.done;

endmodule // sfr_host

// >>> sfr_link_asserts.sv
/*
 Checker for the serial link between the flash controller end and the
 flash read path end.
 Assumes it is instantiated beside the link interface, on the system clock
 with the synchronous active-low reset, and that the link clock idles low.
*/
module sfr_link_asserts (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic sck, // Link clock
  input wire logic cs_n, // Chip enable, active low
  input wire logic [3:0] h_out, // Host drive values
  input wire logic [3:0] h_oe, // Host drive enables
  input wire logic [3:0] d_out, // Device drive values
  input wire logic [3:0] d_oe, // Device drive enables
  input wire logic [3:0] io // Resolved lines
);
  logic sck_q;
  logic [5:0] since_fall;
  logic [5:0] rise_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Both counters saturate so a long idle never wraps into a legal window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      since_fall <= 6'h3F;
      rise_cnt <= 6'h00;
    end else begin
      sck_q <= sck;
      since_fall <= (sck_q && !sck) ? 6'h00 : ((since_fall == 6'h3F) ? 6'h3F : since_fall + 6'h01);
      rise_cnt <= cs_n ? 6'h00 : ((!sck_q && sck && rise_cnt != 6'h3F) ? rise_cnt + 6'h01 : rise_cnt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle;
    cs_n [*6];
  endsequence
  sequence s_shift;
    (d_oe != 4'h0) && ($past(d_oe) != 4'h0) && ((d_out & d_oe) != ($past(d_out) & d_oe));
  endsequence
  sequence s_drive_on;
    $rose(|d_oe);
  endsequence

  property p_no_fight;
    (h_oe & d_oe) == 4'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("host and device drive one line together");

  property p_idle_quiet;
    s_idle |-> d_oe == 4'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("device drives while deselected");

  property p_end_release;
    $rose(cs_n) |-> ##[1:5] d_oe == 4'h0;
  endproperty
  a_end_release: assert property (p_end_release) else $error("device keeps driving after deselect");

  property p_late_data;
    s_drive_on |-> rise_cnt >= 6'd14;
  endproperty
  a_late_data: assert property (p_late_data) else $error("device drives before dummy phase ends");

  property p_dout_fall;
    s_shift |-> since_fall <= 6'd6;
  endproperty
  a_dout_fall: assert property (p_dout_fall) else $error("device output moved away from a falling edge");

  property p_lanes;
    d_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_lanes: assert property (p_lanes) else $error("device enables an illegal lane set");

  property p_oe_steady;
    !cs_n && !$past(cs_n) && ($past(d_oe) != 4'h0) |-> d_oe == $past(d_oe);
  endproperty
  a_oe_steady: assert property (p_oe_steady) else $error("device lane set changed inside a frame");

  property p_host_setup;
    !cs_n && $rose(sck) |-> $stable(h_out) && $stable(h_oe);
  endproperty
  a_host_setup: assert property (p_host_setup) else $error("host changed its lines at a rising edge");

  property p_sck_idle;
    cs_n && $past(cs_n) |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("link clock runs outside a frame");

  property p_cs_rise_low;
    $rose(cs_n) |-> !sck;
  endproperty
  a_cs_rise_low: assert property (p_cs_rise_low) else $error("frame closed with link clock high");

  property p_dev_wins;
    (d_oe != 4'h0) |-> ((io & d_oe) == (d_out & d_oe));
  endproperty
  a_dev_wins: assert property (p_dev_wins) else $error("device lanes not seen on the resolved lines");
endmodule // sfr_link_asserts

// >>> tb_serial_flash_read_path.sv
/*
 Testbench joining the controller end and the read path end over the link.
 Assumes sfr_cfg.svh, sfr_pkg, sfr_if and both ends are compiled first.
*/
`include "sfr_cfg.svh"
module tb_serial_flash_read_path
  import sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_busy, four_line, load_we, load_aux, start, ready, rd_valid, done, busy, refused;
  logic [2:0] dens;
  logic [18:0] load_addr;
  logic [7:0] load_data, opcode, rd_data;
  logic [23:0] address;
  logic [15:0] byte_count;
  int num_errors = 0;
  int cmp_count = 0;
  int ref_cnt = 0;

  sfr_if link ();
  sfr_host i_sfr_host (.clk(clk), .rst_n(rst_n), .link(link.host), .start(start), .opcode(opcode),
    .address(address), .byte_count(byte_count), .four_line_command_mode(four_line), .ready(ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
  sfr_dev i_sfr_dev (.clk(clk), .rst_n(rst_n), .link(link.dev), .write_in_progress_flag(wr_busy),
    .four_line_command_mode(four_line), .density_sel(dens), .load_we(load_we), .load_aux(load_aux),
    .load_addr(load_addr), .load_data(load_data), .busy(busy), .refused(refused));
  sfr_link_asserts i_sfr_link_asserts (.clk(clk), .rst_n(rst_n), .sck(link.sck), .cs_n(link.cs_n),
    .h_out(link.h_out), .h_oe(link.h_oe), .d_out(link.d_out), .d_oe(link.d_oe), .io(link.io));

  always #5 clk = ~clk;
  always @(posedge clk) if (refused === 1'b1) ref_cnt++;

  ////////////////////////////////////////////////////////////////////////////
  // Neighbouring bytes differ except at 3FFFF/40000 and at the 7FFFF wrap to 0, so elsewhere a missed increment shows
  function automatic logic [7:0] pat(input logic aux, input logic [18:0] a);
    return a[7:0] ^ {a[15:11], a[18:16]} ^ (aux ? 8'h5A : 8'hC3);
  endfunction

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic timeout(input string name);
    num_errors++;
    $display("[FAIL] %s expected handshake seen timeout", name);
    wrap_up();
  endtask

  // One frame: preload, request, then compare every byte returned
  task automatic run(input string name, input logic [7:0] op, input logic q, input logic [23:0] a,
                     input int n, input logic [2:0] d, input logic busy_in, input logic silent);
    logic aux;
    logic [18:0] m;
    int got;
    int r0;
    int k;
    aux = (op == `SFR_OP_UID) || (op == `SFR_OP_INFO);
    m = aux ? 19'h001FF : (19'h7FFFF >> d);
    for (k = 0; k < n; k++) begin
      load_we = 1'b1;
      load_aux = aux;
      load_addr = (a[18:0] + k[18:0]) & m;
      load_data = pat(aux, load_addr);
      tick();
    end
    load_we = 1'b0;
    dens = d;
    wr_busy = busy_in;
    four_line = q;
    opcode = op;
    address = a;
    byte_count = n[15:0];
    for (k = 0; k < 2000 && ready !== 1'b1; k++) tick();
    if (ready !== 1'b1) timeout("ready");
    r0 = ref_cnt;
    start = 1'b1;
    tick();
    start = 1'b0;
    got = 0;
    for (k = 0; k < 20000 && done !== 1'b1; k++) begin
      tick();
      if (rd_valid === 1'b1) begin
        chk(name, rd_data, silent ? 8'hFF : pat(aux, (a[18:0] + got[18:0]) & m));
        if (got == 0) chk("busy_in_frame", {7'h00, busy}, 8'h01);
        got++;
      end
    end
    if (done !== 1'b1) timeout("done");
    chk("byte_total", got[7:0], n[7:0]);
    chk("refused_count", 8'(ref_cnt - r0), {7'h00, busy_in});
    repeat (10) tick();
    chk("busy_after", {7'h00, busy}, 8'h00);
    wr_busy = 1'b0;
    $display("test %s done, errors %0d", name, num_errors);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wr_busy = 1'b0;
    four_line = 1'b0;
    load_we = 1'b0;
    load_aux = 1'b0;
    start = 1'b0;
    dens = 3'h0;
    load_addr = 19'h00000;
    load_data = 8'h00;
    opcode = 8'h00;
    address = 24'h000000;
    byte_count = 16'h0000;
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    run("normal", `SFR_OP_NORMAL, 1'b0, 24'hFF1230, 3, 3'h0, 1'b0, 1'b0);
    run("fast", `SFR_OP_FAST, 1'b0, 24'h00ABCD, 5, 3'h0, 1'b0, 1'b0);
    run("dual_out", `SFR_OP_DUAL_OUT, 1'b0, 24'h012345, 3, 3'h0, 1'b0, 1'b0);
    run("dual_io", `SFR_OP_DUAL_IO, 1'b0, 24'h054321, 3, 3'h0, 1'b0, 1'b0);
    run("quad_out", `SFR_OP_QUAD_OUT, 1'b0, 24'h0600F0, 3, 3'h0, 1'b0, 1'b0);
    run("quad_io", `SFR_OP_QUAD_IO, 1'b0, 24'h07FFF0, 3, 3'h0, 1'b0, 1'b0);
    run("fast_four", `SFR_OP_FAST, 1'b1, 24'h0012FE, 3, 3'h0, 1'b0, 1'b0);
    run("quad_io_four", `SFR_OP_QUAD_IO, 1'b1, 24'h0456AB, 3, 3'h0, 1'b0, 1'b0);
    run("uid", `SFR_OP_UID, 1'b0, 24'hABC003, 3, 3'h0, 1'b0, 1'b0);
    run("info_four", `SFR_OP_INFO, 1'b1, 24'h000105, 3, 3'h0, 1'b0, 1'b0);
    for (int d = 0; d < 5; d++) begin
      run("wrap", `SFR_OP_NORMAL, 1'b0, 24'hFFFFFE, 4, d[2:0], 1'b0, 1'b0);
    end
    run("wrap_quad", `SFR_OP_QUAD_IO, 1'b0, 24'hFFFFFF, 2, 3'h4, 1'b0, 1'b0);
    run("busy_fast", `SFR_OP_FAST, 1'b0, 24'h000010, 2, 3'h0, 1'b1, 1'b1);
    run("busy_normal", `SFR_OP_NORMAL, 1'b0, 24'h000020, 1, 3'h0, 1'b1, 1'b1);
    run("after_busy", `SFR_OP_FAST, 1'b0, 24'h000010, 2, 3'h0, 1'b0, 1'b0);
    run("ignored_four", `SFR_OP_NORMAL, 1'b1, 24'h000030, 2, 3'h0, 1'b0, 1'b1);
    wrap_up();
  end
endmodule // tb_serial_flash_read_path
